/* File: hdl/trim_link_map.vh */
// Register offsets, field positions and reset values for the trim, dither, LSB and link enable bank
`ifndef TRIM_LINK_MAP_VH
`define TRIM_LINK_MAP_VH
`define ADDR_W 12
`define OFF_TRIM 12'h07F
`define OFF_DITHER 12'h09D
`define OFF_LSB_CTRL 12'h160
`define OFF_LINK_EN 12'h200
`define RST_TRIM 8'h00
`define RST_DITHER 8'h01
`define RST_LSB_CTRL 8'h00
`define RST_LINK_EN 8'h01
`define BIT_DITHER_ON 0
`define BIT_DITHER_AMP 1
`define BIT_ROUND_ERR 2
`define BIT_TIMESTAMP_ON 0
`define BIT_LINK_ON 0
`define SAMPLE_W 12
`define PIPE_DEPTH 4
`endif

/* File: hdl/adc_trim_dither_link_ctrl.v */
// Register bank for input B trim, dither control, timestamp on sample LSB and serial link enable
// Overview of operation
// RQ1 - An 8-bit read/write input B termination trim loads the factory value at reset and may be overwritten; the code
// resets it to 8'h00 and takes the factory value on the first load request after reset, unless a trim write lands in that same cycle.
// RQ2 - Dither control bit 0 turns dither on and resets to one.
// RQ3 - Dither control bit 1 selects large dither when one and small dither, the reset value, when zero.
// RQ4 - Dither control bit 2 moves the rounding error from SNR to DC offset and the half and quarter rate spurs.
// RQ5 - With the timestamp enable set, each output sample carries the timestamp on its LSB.
// RQ6 - The timestamp is delayed by the same latency as the samples so it stays aligned.
// RQ7 - In 8-bit modes the LSB is replaced keeping seven data bits, in 12-bit modes keeping eleven.
// RQ8 - The control-bits-per-sample value advertised in lane alignment stays zero even with the timestamp on.
// RQ9 - Software sets the timestamp input receiver enable whenever it enables the timestamp.
// RQ10 - Serial link enable bit 0 enables the serial interface when one and resets to one.
// RQ11 - With the link enable zero the serial block is held in reset, serializers powered down, clocks gated.
// RQ12 - With the link enable zero the local multiframe counter is held in reset so SYSREF causes no alignment.
// RQ13 - Software clears the link enable before changing other serial link configuration.
// RQ14 - Software sets calibration enable before link enable and clears link enable before calibration enable.
// RQ15 - Every register, reserved bits included, reads back the last write and acts from the next clock edge; trim is overwritten by its first factory load.
`timescale 1ns/1ps
`include "trim_link_map.vh"
module adc_trim_dither_link_ctrl #(
	parameter [7:0] TRIM_FACTORY = 8'h00
) (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire [`ADDR_W-1:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output wire [7:0] rdata_o,
	input wire fuse_load_i,
	input wire mode_8bit_i,
	input wire [`SAMPLE_W-1:0] sample_i,
	input wire timestamp_i,
	output wire [`SAMPLE_W-1:0] sample_o,
	output wire [7:0] input_b_termination_trim_o,
	output wire dither_on_o,
	output wire dither_amplitude_select_o,
	output wire rounding_error_target_o,
	output wire timestamp_on_lsb_o,
	output wire [1:0] ilas_control_bits_o,
	output wire serial_link_on_o,
	output wire link_reset_n_o,
	output wire serializer_power_o,
	output wire link_clk_enable_o,
	output wire mf_counter_reset_n_o
);
	reg [7:0] trim_q;
	reg [7:0] dither_q;
	reg [7:0] lsb_ctrl_q;
	reg [7:0] link_en_q;
	reg [7:0] rdata_q;
	reg [`SAMPLE_W-1:0] samp_pipe_q [0:`PIPE_DEPTH-1];
	reg [`PIPE_DEPTH-1:0] ts_pipe_q;
	reg [`SAMPLE_W-1:0] sample_q;
	reg fuse_seen_q;
	reg [7:0] trim_d;
	reg [7:0] dither_d;
	reg [7:0] lsb_ctrl_d;
	reg [7:0] link_en_d;
	reg [7:0] rdata_d;
	reg fuse_seen_d;
	reg [`SAMPLE_W-1:0] sample_d;
	wire [`SAMPLE_W-1:0] samp_last;
	wire ts_last;
	genvar g;

	function hit;
		input [`ADDR_W-1:0] a;
		input [`ADDR_W-1:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	// Factory trim is taken on the first load request after reset only (see RQ1)
	always @* begin
		fuse_seen_d = fuse_seen_q;
		if (fuse_load_i) begin
			fuse_seen_d = 1'b1;
		end
	end

	// A write beats a factory load in the same cycle, but a write made before the first load is overwritten by it
	always @* begin
		trim_d = trim_q;
		if (wr_i && hit(addr_i, `OFF_TRIM)) begin
			trim_d = wdata_i; // see RQ1, RQ15
		end else if (fuse_load_i && !fuse_seen_q) begin
			trim_d = TRIM_FACTORY; // see RQ1
		end
	end

	// Reserved bits are stored too, so the dither, LSB control and link enable registers read back the last write (see RQ15)
	always @* begin
		dither_d = dither_q;
		lsb_ctrl_d = lsb_ctrl_q;
		link_en_d = link_en_q;
		if (wr_i && hit(addr_i, `OFF_DITHER)) begin
			dither_d = wdata_i; // see RQ2, RQ3, RQ4
		end
		if (wr_i && hit(addr_i, `OFF_LSB_CTRL)) begin
			lsb_ctrl_d = wdata_i; // see RQ5
		end
		if (wr_i && hit(addr_i, `OFF_LINK_EN)) begin
			link_en_d = wdata_i; // see RQ10
		end
	end

	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			trim_q <= `RST_TRIM;
			dither_q <= `RST_DITHER; // see RQ2, RQ3
			lsb_ctrl_q <= `RST_LSB_CTRL;
			link_en_q <= `RST_LINK_EN; // see RQ10
			fuse_seen_q <= 1'b0;
		end else begin
			trim_q <= trim_d;
			dither_q <= dither_d;
			lsb_ctrl_q <= lsb_ctrl_d;
			link_en_q <= link_en_d;
			fuse_seen_q <= fuse_seen_d;
		end
	end

	// Read data stand one cycle after the strobe; unmapped addresses and idle cycles read zero
	always @* begin
		rdata_d = 8'h00;
		if (rd_i) begin
			if (hit(addr_i, `OFF_TRIM)) begin
				rdata_d = trim_q;
			end else if (hit(addr_i, `OFF_DITHER)) begin
				rdata_d = dither_q;
			end else if (hit(addr_i, `OFF_LSB_CTRL)) begin
				rdata_d = lsb_ctrl_q;
			end else if (hit(addr_i, `OFF_LINK_EN)) begin
				rdata_d = link_en_q;
			end else begin
				rdata_d = 8'h00;
			end
		end
	end

	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d; // see RQ15
		end
	end
	assign rdata_o = rdata_q;

	// Sample and timestamp share one pipeline so their latency is equal by construction (see RQ6)
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			samp_pipe_q[0] <= {`SAMPLE_W{1'b0}};
			ts_pipe_q[0] <= 1'b0;
		end else begin
			samp_pipe_q[0] <= sample_i;
			ts_pipe_q[0] <= timestamp_i;
		end
	end
	generate
		for (g = 1; g < `PIPE_DEPTH; g = g + 1) begin : stage
			always @(posedge core_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					samp_pipe_q[g] <= {`SAMPLE_W{1'b0}};
					ts_pipe_q[g] <= 1'b0;
				end else begin
					samp_pipe_q[g] <= samp_pipe_q[g-1];
					ts_pipe_q[g] <= ts_pipe_q[g-1]; // see RQ6
				end
			end
		end
	endgenerate
	assign samp_last = samp_pipe_q[`PIPE_DEPTH-1];
	assign ts_last = ts_pipe_q[`PIPE_DEPTH-1];

	// 8-bit samples sit in the upper byte, so the marked LSB is bit 4 there (see RQ7)
	always @* begin
		sample_d = samp_last;
		if (lsb_ctrl_q[`BIT_TIMESTAMP_ON]) begin
			if (mode_8bit_i) begin
				sample_d = {samp_last[`SAMPLE_W-1:5], ts_last, 4'h0}; // see RQ5, RQ7
			end else begin
				sample_d = {samp_last[`SAMPLE_W-1:1], ts_last}; // see RQ5, RQ7
			end
		end
	end
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sample_q <= {`SAMPLE_W{1'b0}};
		end else begin
			sample_q <= sample_d;
		end
	end
	assign sample_o = sample_q;

	assign input_b_termination_trim_o = trim_q;
	assign dither_on_o = dither_q[`BIT_DITHER_ON]; // see RQ2
	assign dither_amplitude_select_o = dither_q[`BIT_DITHER_AMP]; // see RQ3
	assign rounding_error_target_o = dither_q[`BIT_ROUND_ERR]; // see RQ4
	assign timestamp_on_lsb_o = lsb_ctrl_q[`BIT_TIMESTAMP_ON];
	// Never advertised, even with the timestamp on (see RQ8)
	assign ilas_control_bits_o = 2'h0;
	assign serial_link_on_o = link_en_q[`BIT_LINK_ON]; // see RQ10
	assign link_reset_n_o = link_en_q[`BIT_LINK_ON]; // see RQ11
	assign serializer_power_o = link_en_q[`BIT_LINK_ON]; // see RQ11
	assign link_clk_enable_o = link_en_q[`BIT_LINK_ON]; // see RQ11
	assign mf_counter_reset_n_o = link_en_q[`BIT_LINK_ON]; // see RQ12
endmodule

/* File: verif/trim_link_chk.sv */
// Port checker for the trim, dither, LSB and link enable bank
`timescale 1ns/1ps
`include "trim_link_map.vh"
module trim_link_chk (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire [`ADDR_W-1:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	input wire [7:0] rdata_o,
	input wire fuse_load_i,
	input wire [7:0] input_b_termination_trim_o,
	input wire dither_amplitude_select_o,
	input wire serializer_power_o,
	input wire link_clk_enable_o,
	input wire mode_8bit_i,
	input wire [`SAMPLE_W-1:0] sample_i,
	input wire timestamp_i,
	input wire [`SAMPLE_W-1:0] sample_o,
	input wire dither_on_o,
	input wire rounding_error_target_o,
	input wire timestamp_on_lsb_o,
	input wire [1:0] ilas_control_bits_o,
	input wire serial_link_on_o,
	input wire link_reset_n_o,
	input wire mf_counter_reset_n_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_wr(a);
		wr_i && addr_i == a;
	endsequence
	a_trim_write: assert property (s_wr(`OFF_TRIM) |=> input_b_termination_trim_o == $past(wdata_i))
		else $error("trim write");
	a_trim_hold: assert property (!(wr_i && addr_i == `OFF_TRIM) && !fuse_load_i |=>
		$stable(input_b_termination_trim_o))
		else $error("trim hold");
	a_dither_on: assert property (s_wr(`OFF_DITHER) |=> dither_on_o == $past(wdata_i[0]))
		else $error("dither on");
	a_dither_amp: assert property (s_wr(`OFF_DITHER) |=> dither_amplitude_select_o == $past(wdata_i[1]))
		else $error("dither amp");
	a_round_target: assert property (s_wr(`OFF_DITHER) |=> rounding_error_target_o == $past(wdata_i[2]))
		else $error("round target");
	a_ts_enable: assert property (s_wr(`OFF_LSB_CTRL) |=> timestamp_on_lsb_o == $past(wdata_i[0]))
		else $error("ts enable");
	a_link_write: assert property (s_wr(`OFF_LINK_EN) |=> serial_link_on_o == $past(wdata_i[0]))
		else $error("link enable");
	a_link_held: assert property (!serial_link_on_o |->
		!link_reset_n_o && !serializer_power_o && !link_clk_enable_o && !mf_counter_reset_n_o)
		else $error("link hold");
	a_link_run: assert property (serial_link_on_o |->
		link_reset_n_o && serializer_power_o && link_clk_enable_o && mf_counter_reset_n_o)
		else $error("link run");
	a_ilas_zero: assert property (ilas_control_bits_o == 2'h0)
		else $error("ilas bits");
	a_rd_idle: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("rdata idle");
	// Enable must stand six cycles so the whole pipe was filled under it
	a_ts_align: assert property ((rst_n_i && timestamp_on_lsb_o && !mode_8bit_i)[*6] |->
		sample_o[0] == $past(timestamp_i, 5))
		else $error("ts align");
	a_data_bits: assert property ((rst_n_i && !mode_8bit_i)[*6] |->
		sample_o[11:1] == $past(sample_i[11:1], 5))
		else $error("data bits");
	a_ts_8bit: assert property ((rst_n_i && timestamp_on_lsb_o && mode_8bit_i)[*6] |->
		sample_o[11:4] == {$past(sample_i[11:5], 5), $past(timestamp_i, 5)})
		else $error("ts 8bit");
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the trim, dither, LSB and link enable bank
`timescale 1ns/1ps
`include "trim_link_map.vh"
module tb_top;
	reg core_clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, fuse_load_i = 0, mode_8bit_i = 0, timestamp_i = 0, t;
	reg [11:0] addr_i = 0, sample_i = 0, s;
	reg [7:0] wdata_i = 0, m[4];
	wire [7:0] rdata_o;
	wire [11:0] sample_o;
	reg [11:0] ad[4] = '{`OFF_TRIM, `OFF_DITHER, `OFF_LSB_CTRL, `OFF_LINK_EN};
	reg [11:0] q[$];
	int failures = 0, samples_checked = 0, i, k;
	always #12.5 core_clk_i = ~core_clk_i;
	adc_trim_dither_link_ctrl #(.TRIM_FACTORY(8'h5A)) i_adc_trim_dither_link_ctrl (.core_clk_i, .rst_n_i, .addr_i,
		.wdata_i, .wr_i, .rd_i, .rdata_o, .fuse_load_i, .mode_8bit_i, .sample_i, .timestamp_i, .sample_o,
		.input_b_termination_trim_o(), .dither_on_o(), .dither_amplitude_select_o(), .rounding_error_target_o(),
		.timestamp_on_lsb_o(), .ilas_control_bits_o(), .serial_link_on_o(), .link_reset_n_o(),
		.serializer_power_o(), .link_clk_enable_o(), .mf_counter_reset_n_o());
	task chk_reg(input [7:0] g, e);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("mismatch %0t rdata got %h want %h", $time, g, e);
		end
	endtask
	task chk_samp(input [11:0] g, e);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("mismatch %0t sample got %h want %h", $time, g, e);
		end
	endtask
	// Strobes drop at the sampling edge, so a following access raises them in a later step
	task acc(input w, input [11:0] a, input [7:0] d);
		wr_i <= w;
		rd_i <= !w;
		addr_i <= a;
		wdata_i <= d;
		@(posedge core_clk_i);
		wr_i <= 0;
		rd_i <= 0;
		#1;
		if (!w) chk_reg(rdata_o, d);
	endtask
	task samp(input m8, ts);
		mode_8bit_i <= m8;
		q.delete();
		for (k = 0; k < 40; k++) begin
			s = $urandom;
			t = $urandom;
			sample_i <= s;
			timestamp_i <= t;
			q.push_back(m8 ? {s[11:5], ts ? t : s[4], 4'h0} : {s[11:1], ts ? t : s[0]});
			@(posedge core_clk_i);
			#1;
			if (q.size() == 5) chk_samp(sample_o, q.pop_front());
		end
	endtask
	task finish_test;
		if (failures == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		i = $urandom(40975);
		m = '{8'h00, 8'h01, 8'h00, 8'h01};
		repeat (3) @(posedge core_clk_i);
		rst_n_i <= 1;
		#1;
		for (i = 0; i < 4; i++) acc(0, ad[i], m[i]);
		fuse_load_i <= 1;
		@(posedge core_clk_i);
		fuse_load_i <= 0;
		#1;
		m[0] = 8'h5A;
		acc(0, ad[0], m[0]);
		for (k = 0; k < 12; k++) begin
			m[k % 4] = $urandom;
			acc(1, ad[k % 4], m[k % 4]);
			acc(0, ad[k % 4], m[k % 4]);
		end
		acc(1, 12'h07E, 8'hFF);
		acc(0, 12'h07E, 8'h00);
		acc(1, ad[2], 8'h01);
		samp(0, 1);
		samp(1, 1);
		acc(1, ad[2], 8'h00);
		samp(0, 0);
		acc(1, ad[3], 8'h00);
		acc(1, ad[3], 8'h01);
		for (i = 0; i < 2; i++) acc(0, ad[i], m[i]);
		fuse_load_i <= 1;
		acc(0, ad[1], m[1]);
		fuse_load_i <= 0;
		acc(0, ad[0], m[0]);
		rst_n_i <= 0;
		repeat (3) @(posedge core_clk_i);
		rst_n_i <= 1;
		#1;
		fuse_load_i <= 1;
		acc(1, ad[0], 8'h3C);
		fuse_load_i <= 0;
		acc(0, ad[0], 8'h3C);
		for (i = 1; i < 4; i++) acc(0, ad[i], i[0] ? 8'h01 : 8'h00);
		finish_test;
	end
endmodule
bind adc_trim_dither_link_ctrl trim_link_chk i_trim_link_chk (.core_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
	.rd_i, .rdata_o, .fuse_load_i, .input_b_termination_trim_o, .dither_amplitude_select_o, .serializer_power_o,
	.link_clk_enable_o, .mode_8bit_i, .sample_i, .timestamp_i, .sample_o, .dither_on_o, .rounding_error_target_o,
	.timestamp_on_lsb_o, .ilas_control_bits_o, .serial_link_on_o, .link_reset_n_o, .mf_counter_reset_n_o);
